// ===== ddrc_pkg.sv
/*
  Constants and types shared by the double-data-rate pin cell and its
  dual-edge flip-flop. Assumes one system clock; both phase clocks are
  modelled as alternating one-cycle enables derived from it.
*/
package ddrc_pkg;

  // system clock and phase clock timing
  localparam int SYS_CLK_PERIOD_NS = 50;
  localparam int PHASE_HIGH_NS = 50;
  localparam int PHASE_HIGH_CYCLES = (PHASE_HIGH_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

  // which phase clock is high during the current system cycle
  typedef enum logic [0:0] {
    DDRC_PH_A = 1'b0,
    DDRC_PH_B = 1'b1
  } ddrc_phase_t;

  localparam ddrc_phase_t PHASE_RESET = DDRC_PH_B;

  // power-up value of every storage element except phase_reg and live_reg
  localparam logic REG_RESET = 1'b0;
  localparam logic SET_LEVEL = 1'b1;

  // polarity-swap mask, one bit for each of the ten pin-path cell inputs
  localparam int INV_W = 10;
  localparam int INV_DATA_A = 0;
  localparam int INV_DATA_B = 1;
  localparam int INV_TRI_A = 2;
  localparam int INV_TRI_B = 3;
  localparam int INV_SET = 4;
  localparam int INV_RESET = 5;
  localparam int INV_OUT_CE = 6;
  localparam int INV_TRI_CE = 7;
  localparam int INV_IN_CE = 8;
  localparam int INV_PIN_IN = 9;

endpackage : ddrc_pkg

// ===== ddrc_dual_edge_flop.sv
/*
  Dual-edge flip-flop: loads one data input on the phase A edge and the
  other on the phase B edge. Synchronous set/reset or asynchronous-style
  preset/clear, chosen by a parameter. Assumes edge_a and edge_b are
  mutually exclusive one-cycle enables from the parent's phase divider.
*/
`timescale 1ns/1ns
`default_nettype none

module ddrc_dual_edge_flop #(
  parameter bit ASYNC_VARIANT = 1'b0
) (
  input wire logic sys_clk, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic edge_a, // phase a rising edge enable
  input wire logic edge_b, // phase b rising edge enable
  input wire logic first_data_in, // loaded on phase a edge
  input wire logic second_data_in, // loaded on phase b edge
  input wire logic clk_en, // clock enable
  input wire logic set_in, // set or preset
  input wire logic reset_in, // reset or clear
  output logic q // flop output
);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      q <= ddrc_pkg::REG_RESET;
    end else if (ASYNC_VARIANT) begin
      // preset/clear act on any system cycle, not only on a phase edge
      if (reset_in) begin
        q <= ddrc_pkg::REG_RESET;
      end else if (set_in) begin
        q <= ddrc_pkg::SET_LEVEL;
      end else if (clk_en && edge_a) begin
        q <= first_data_in;
      end else if (clk_en && edge_b) begin
        q <= second_data_in;
      end
    end else if (edge_a || edge_b) begin
      if (reset_in) begin
        q <= ddrc_pkg::REG_RESET;
      end else if (set_in) begin
        q <= ddrc_pkg::SET_LEVEL;
      end else if (clk_en) begin
        q <= edge_a ? first_data_in : second_data_in;
      end
    end
  end

  // the edge that releases reset still clears q; checks start one edge later
  logic live_reg;

  always_ff @(posedge sys_clk) begin
    live_reg <= rst_b;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b || !live_reg);

  property p_hold_no_enable;
    (!clk_en && !set_in && !reset_in) |=> $stable(q);
  endproperty
  a_hold_no_enable: assert property (p_hold_no_enable)
    else $error("flop changed with enable low");

  generate
    if (ASYNC_VARIANT) begin : g_async
      property p_clear_wins;
        reset_in |=> (q == 1'b0);
      endproperty
      a_clear_wins: assert property (p_clear_wins)
        else $error("clear did not force low");
      property p_preset;
        (set_in && !reset_in) |=> (q == 1'b1);
      endproperty
      a_preset: assert property (p_preset)
        else $error("preset did not force high");
      property p_async_load;
        (clk_en && !set_in && !reset_in && edge_b) |=> (q == $past(second_data_in));
      endproperty
      a_async_load: assert property (p_async_load)
        else $error("second data not loaded on phase b edge");
    end else begin : g_sync
      property p_reset_first;
        (reset_in && (edge_a || edge_b)) |=> (q == 1'b0);
      endproperty
      a_reset_first: assert property (p_reset_first)
        else $error("reset did not win");
      property p_sync_set;
        (set_in && !reset_in && (edge_a || edge_b)) |=> (q == 1'b1);
      endproperty
      a_sync_set: assert property (p_sync_set)
        else $error("set did not drive high");
      property p_sync_load;
        (clk_en && !set_in && !reset_in && edge_a) |=> (q == $past(first_data_in));
      endproperty
      a_sync_load: assert property (p_sync_load)
        else $error("first data not loaded on phase a edge");
    end
  endgenerate

endmodule : ddrc_dual_edge_flop

`default_nettype wire

// ===== ddrc_io_cell.sv
/*
  Double-data-rate pin cell: input capture pair, output data pair with
  tri-state pair and pin multiplexer, plus one synchronous and one
  asynchronous-style dual-edge flip-flop for general use. Assumes a single
  system clock; the two opposite phase clocks are each one system cycle
  high, alternately, and all inputs are synchronous to sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none

// How it works
// - pin input feeds two capture registers, one per opposite phase clock
// - with input enable high, bits alternate into first and second capture
// - every data, tri-state and capture register shares one set line and one reset line
// - pin multiplexer alternates between first and second output data registers
// - both output data registers share one enable; load data only while high
// - multiplexer select comes from the phase clock alone
// - pin shows data mux or high impedance, enable from tri-state mux
// - separate enables for data registers and tri-state registers
// - phase a drives one data and one tri-state register, phase b the others
// - both tri-state high gives high impedance; both low gives data
// - tri a high, b low: hi-z in phase a, data b in phase b
// - tri b high, a low: hi-z in phase b, data a in phase a
// - tri-state and data registers share the same output phase clocks
// - the ten pin-path inputs invertible without delay; phase b is inverted phase a
// - sync flop loads first data on phase a, second on phase b
// - enable low: no load; async flop ignores clock edges
// - sync flop reset overrides everything, drives low on any edge
// - sync flop set, reset low, drives high on any edge
// - both flops and all registers except phase_reg clear low at power-up
// - async flop loads data only with preset, clear low, enable high
// - async flop preset forces high, clear forces low, no edge needed
module ddrc_io_cell (
  input wire logic sys_clk, // system clock, 20 MHz
  input wire logic rst_b, // synchronous reset, active low
  input wire logic [ddrc_pkg::INV_W-1:0] invert_mask, // per-input polarity swap
  input wire logic cell_set, // common set line
  input wire logic cell_reset, // common reset line
  input wire logic in_ce, // input capture enable
  input wire logic out_ce, // output data enable
  input wire logic tri_ce, // tri-state control enable
  input wire logic first_data_in, // data for phase a slot
  input wire logic second_data_in, // data for phase b slot
  input wire logic tri_in_a, // tri-state request, phase a slot
  input wire logic tri_in_b, // tri-state request, phase b slot
  input wire logic pin_i, // pad level seen by the cell
  output logic pin_o, // pad drive value
  output logic pin_oe, // pad driven when high
  output logic rise_capture_out, // bit taken on phase a edge
  output logic fall_capture_out, // bit taken on phase b edge
  output logic phase_a_clock, // high while phase a is high
  input wire logic sflop_d0, // sync flop first data
  input wire logic sflop_d1, // sync flop second data
  input wire logic sflop_ce, // sync flop enable
  input wire logic sflop_set, // sync flop set
  input wire logic sflop_reset, // sync flop reset
  output logic sflop_q, // sync flop output
  input wire logic aflop_d0, // async flop first data
  input wire logic aflop_d1, // async flop second data
  input wire logic aflop_ce, // async flop enable
  input wire logic aflop_preset, // async flop preset
  input wire logic async_reset, // async flop clear
  output logic aflop_q // async flop output
);

  // swap polarity of one input; pure gating, no added register stage
  function automatic logic pol(input logic v, input logic [ddrc_pkg::INV_W-1:0] m,
                               input int pos);
    pol = v ^ m[pos];
  endfunction : pol

  // one register of a phase pair: reset beats set beats load
  function automatic logic pair_next(input logic cur, input logic d, input logic edge_hit,
                                     input logic ce, input logic set_l, input logic rst_l);
    if (!edge_hit) begin
      pair_next = cur;
    end else if (rst_l) begin
      pair_next = ddrc_pkg::REG_RESET;
    end else if (set_l) begin
      pair_next = ddrc_pkg::SET_LEVEL;
    end else if (ce) begin
      pair_next = d;
    end else begin
      pair_next = cur;
    end
  endfunction : pair_next

  ddrc_pkg::ddrc_phase_t phase_reg;
  logic edge_a;
  logic edge_b;
  logic data_a_eff;
  logic data_b_eff;
  logic tri_a_eff;
  logic tri_b_eff;
  logic set_eff;
  logic reset_eff;
  logic out_ce_eff;
  logic tri_ce_eff;
  logic in_ce_eff;
  logic pin_in_eff;
  logic data_reg_a;
  logic data_reg_b;
  logic tristate_reg_a;
  logic tristate_reg_b;
  logic data_a_next;
  logic data_b_next;
  logic tri_a_next;
  logic tri_b_next;

  assign data_a_eff = pol(first_data_in, invert_mask, ddrc_pkg::INV_DATA_A);
  assign data_b_eff = pol(second_data_in, invert_mask, ddrc_pkg::INV_DATA_B);
  assign tri_a_eff = pol(tri_in_a, invert_mask, ddrc_pkg::INV_TRI_A);
  assign tri_b_eff = pol(tri_in_b, invert_mask, ddrc_pkg::INV_TRI_B);
  assign set_eff = pol(cell_set, invert_mask, ddrc_pkg::INV_SET);
  assign reset_eff = pol(cell_reset, invert_mask, ddrc_pkg::INV_RESET);
  assign out_ce_eff = pol(out_ce, invert_mask, ddrc_pkg::INV_OUT_CE);
  assign tri_ce_eff = pol(tri_ce, invert_mask, ddrc_pkg::INV_TRI_CE);
  assign in_ce_eff = pol(in_ce, invert_mask, ddrc_pkg::INV_IN_CE);
  assign pin_in_eff = pol(pin_i, invert_mask, ddrc_pkg::INV_PIN_IN);

  // phase divider: each phase clock is high for one system cycle;
  // phase b is the inverse of phase a, so the two are 180 degrees apart
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      phase_reg <= ddrc_pkg::PHASE_RESET;
    end else begin
      case (phase_reg)
        ddrc_pkg::DDRC_PH_A: phase_reg <= ddrc_pkg::DDRC_PH_B;
        ddrc_pkg::DDRC_PH_B: phase_reg <= ddrc_pkg::DDRC_PH_A;
        default: phase_reg <= ddrc_pkg::PHASE_RESET;
      endcase
    end
  end

  // rising edge of a phase is the edge that ends the other phase
  assign edge_a = (phase_reg == ddrc_pkg::DDRC_PH_B);
  assign edge_b = (phase_reg == ddrc_pkg::DDRC_PH_A);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      phase_a_clock <= ddrc_pkg::REG_RESET;
    end else begin
      phase_a_clock <= edge_a;
    end
  end

  // input path: same pin level offered to both registers, each on its own edge
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rise_capture_out <= ddrc_pkg::REG_RESET;
      fall_capture_out <= ddrc_pkg::REG_RESET;
    end else begin
      rise_capture_out <= pair_next(rise_capture_out, pin_in_eff, edge_a, in_ce_eff,
                                    set_eff, reset_eff);
      fall_capture_out <= pair_next(fall_capture_out, pin_in_eff, edge_b, in_ce_eff,
                                    set_eff, reset_eff);
    end
  end

  // output pairs: data and tri-state registers on the same phase form a pair
  always_comb begin
    data_a_next = pair_next(data_reg_a, data_a_eff, edge_a, out_ce_eff, set_eff,
                            reset_eff);
    data_b_next = pair_next(data_reg_b, data_b_eff, edge_b, out_ce_eff, set_eff,
                            reset_eff);
    tri_a_next = pair_next(tristate_reg_a, tri_a_eff, edge_a, tri_ce_eff, set_eff,
                           reset_eff);
    tri_b_next = pair_next(tristate_reg_b, tri_b_eff, edge_b, tri_ce_eff, set_eff,
                           reset_eff);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      data_reg_a <= ddrc_pkg::REG_RESET;
      data_reg_b <= ddrc_pkg::REG_RESET;
      tristate_reg_a <= ddrc_pkg::REG_RESET;
      tristate_reg_b <= ddrc_pkg::REG_RESET;
    end else begin
      data_reg_a <= data_a_next;
      data_reg_b <= data_b_next;
      tristate_reg_a <= tri_a_next;
      tristate_reg_b <= tri_b_next;
    end
  end

  // pin mux registered from the next values so the pad shows a register in
  // the same cycle it loads; select is the phase only, no user select
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pin_o <= ddrc_pkg::REG_RESET;
      pin_oe <= ddrc_pkg::REG_RESET;
    end else if (edge_a) begin
      pin_o <= data_a_next;
      pin_oe <= !tri_a_next;
    end else begin
      pin_o <= data_b_next;
      pin_oe <= !tri_b_next;
    end
  end

  ddrc_dual_edge_flop #(
    .ASYNC_VARIANT(1'b0)
  ) u_sync_flop (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .edge_a(edge_a),
    .edge_b(edge_b),
    .first_data_in(sflop_d0),
    .second_data_in(sflop_d1),
    .clk_en(sflop_ce),
    .set_in(sflop_set),
    .reset_in(sflop_reset),
    .q(sflop_q)
  );

  ddrc_dual_edge_flop #(
    .ASYNC_VARIANT(1'b1)
  ) u_async_flop (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .edge_a(edge_a),
    .edge_b(edge_b),
    .first_data_in(aflop_d0),
    .second_data_in(aflop_d1),
    .clk_en(aflop_ce),
    .set_in(aflop_preset),
    .reset_in(async_reset),
    .q(aflop_q)
  );

  // checks start one edge after reset lets go: the releasing edge still
  // runs the reset branch, so inputs sampled there never load
  logic live_reg;

  always_ff @(posedge sys_clk) begin
    live_reg <= rst_b;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b || !live_reg);

  property p_phase_alternates;
    (phase_reg == ddrc_pkg::DDRC_PH_A) |=> (phase_reg == ddrc_pkg::DDRC_PH_B) ##1
      (phase_reg == ddrc_pkg::DDRC_PH_A);
  endproperty
  a_phase_alternates: assert property (p_phase_alternates)
    else $error("phase clocks not alternating");

  property p_phase_clock_out;
    phase_a_clock == (phase_reg == ddrc_pkg::DDRC_PH_A);
  endproperty
  a_phase_clock_out: assert property (p_phase_clock_out)
    else $error("phase clock output does not follow mux select");

  property p_capture_a;
    (edge_a && in_ce_eff && !set_eff && !reset_eff) |=>
      (rise_capture_out == $past(pin_in_eff)) && $stable(fall_capture_out);
  endproperty
  a_capture_a: assert property (p_capture_a)
    else $error("phase a capture wrong");

  property p_capture_b;
    (edge_b && in_ce_eff && !set_eff && !reset_eff) |=>
      (fall_capture_out == $past(pin_in_eff)) && $stable(rise_capture_out);
  endproperty
  a_capture_b: assert property (p_capture_b)
    else $error("phase b capture wrong");

  property p_capture_alternate;
    (in_ce_eff && !set_eff && !reset_eff)[*2] |->
      (fall_capture_out == $past(pin_in_eff)) || (rise_capture_out == $past(pin_in_eff));
  endproperty
  a_capture_alternate: assert property (p_capture_alternate)
    else $error("input bits not captured alternately");

  property p_common_reset;
    reset_eff [*2] |=> !data_reg_a && !data_reg_b && !tristate_reg_a && !tristate_reg_b
      && !rise_capture_out && !fall_capture_out;
  endproperty
  a_common_reset: assert property (p_common_reset)
    else $error("common reset missed a register");

  property p_data_hold;
    (!out_ce_eff && !set_eff && !reset_eff) |=> $stable(data_reg_a) && $stable(data_reg_b);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data register changed with enable low");

  property p_tri_hold;
    (!tri_ce_eff && !set_eff && !reset_eff) |=>
      $stable(tristate_reg_a) && $stable(tristate_reg_b);
  endproperty
  a_tri_hold: assert property (p_tri_hold)
    else $error("tri-state register changed with enable low");

  property p_pin_mux;
    pin_oe |-> (pin_o == ((phase_reg == ddrc_pkg::DDRC_PH_A) ? data_reg_a : data_reg_b));
  endproperty
  a_pin_mux: assert property (p_pin_mux)
    else $error("pin does not carry the phase data register");

  property p_both_high;
    (tristate_reg_a && tristate_reg_b) |-> !pin_oe;
  endproperty
  a_both_high: assert property (p_both_high)
    else $error("pin driven with both tri-state registers high");

  property p_both_low;
    (!tristate_reg_a && !tristate_reg_b) |-> pin_oe;
  endproperty
  a_both_low: assert property (p_both_low)
    else $error("pin released with both tri-state registers low");

  property p_tri_a_only;
    (tristate_reg_a && !tristate_reg_b) |->
      ((phase_reg == ddrc_pkg::DDRC_PH_A) ? !pin_oe : (pin_oe && pin_o == data_reg_b));
  endproperty
  a_tri_a_only: assert property (p_tri_a_only)
    else $error("mixed tri-state a high misbehaves");

  property p_tri_b_only;
    (!tristate_reg_a && tristate_reg_b) |->
      ((phase_reg == ddrc_pkg::DDRC_PH_B) ? !pin_oe : (pin_oe && pin_o == data_reg_a));
  endproperty
  a_tri_b_only: assert property (p_tri_b_only)
    else $error("mixed tri-state b high misbehaves");

  property p_cov_ddr_out;
    (pin_oe && pin_o) ##1 (pin_oe && !pin_o);
  endproperty
  c_ddr_out: cover property (p_cov_ddr_out);

  property p_cov_mixed;
    (tristate_reg_a && !tristate_reg_b) ##1 pin_oe;
  endproperty
  c_mixed: cover property (p_cov_mixed);

  property p_cov_capture;
    (in_ce_eff && rise_capture_out) ##1 (in_ce_eff && !fall_capture_out);
  endproperty
  c_capture: cover property (p_cov_capture);

  property p_cov_tri_b_mixed;
    (!tristate_reg_a && tristate_reg_b) ##1 pin_oe;
  endproperty
  c_tri_b_mixed: cover property (p_cov_tri_b_mixed);

endmodule : ddrc_io_cell

`default_nettype wire

// ===== ddrc_pad_model.sv
/*
  Behavioural model of the external device on the far side of the pad.
  Assumes the bench resolves the pad level from this model and the cell.
*/
`timescale 1ns/1ns
`default_nettype none

module ddrc_pad_model (
  input wire logic sys_clk, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic drive_req, // device wants to drive the pad
  input wire logic drive_bit, // value put on the pad when driving
  output logic dev_o // level the device side presents
);
  // no pull on this pad: a released line must not look like held data
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      dev_o <= 1'b0;
    end else if (drive_req) begin
      dev_o <= drive_bit;
    end else begin
      dev_o <= ~dev_o;
    end
  end
endmodule : ddrc_pad_model

`default_nettype wire

// ===== ddrc_io_cell_tb.sv
/*
  Self-checking bench for the pin cell: directed corners, then seeded random
  traffic, checked each cycle against a reference model of the bench.
  Assumes the pad is driven by the cell when pin_oe is high.
*/
`timescale 1ns/1ns
`default_nettype none

module ddrc_io_cell_tb;
  logic sys_clk, rst_b, cell_set, cell_reset, in_ce, out_ce, tri_ce;
  logic first_data_in, second_data_in, tri_in_a, tri_in_b, pad_level, dev_o;
  logic [ddrc_pkg::INV_W-1:0] invert_mask;
  logic pin_o, pin_oe, rise_capture_out, fall_capture_out, phase_a_clock;
  logic sflop_d0, sflop_d1, sflop_ce, sflop_set, sflop_reset, sflop_q;
  logic aflop_d0, aflop_d1, aflop_ce, aflop_preset, async_reset, aflop_q;
  logic drive_req, drive_bit, rs, st, nd, nt;
  logic m_ph, m_cra, m_crb, m_dra, m_drb, m_tra, m_trb, m_po, m_poe, m_sq, m_aq;
  logic [31:0] seed, r;
  logic [4:0] dir;
  bit dir_on, chk_on;
  int failures, tests_run;
  logic [4:0] ctl [3] = '{5'b11100, 5'b10100, 5'b00000};

  assign pad_level = pin_oe ? pin_o : dev_o;

  ddrc_io_cell u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .invert_mask(invert_mask),
    .cell_set(cell_set), .cell_reset(cell_reset), .in_ce(in_ce), .out_ce(out_ce),
    .tri_ce(tri_ce), .first_data_in(first_data_in), .second_data_in(second_data_in),
    .tri_in_a(tri_in_a), .tri_in_b(tri_in_b), .pin_i(pad_level), .pin_o(pin_o),
    .pin_oe(pin_oe), .rise_capture_out(rise_capture_out),
    .fall_capture_out(fall_capture_out), .phase_a_clock(phase_a_clock),
    .sflop_d0(sflop_d0), .sflop_d1(sflop_d1), .sflop_ce(sflop_ce), .sflop_set(sflop_set),
    .sflop_reset(sflop_reset), .sflop_q(sflop_q), .aflop_d0(aflop_d0), .aflop_d1(aflop_d1),
    .aflop_ce(aflop_ce), .aflop_preset(aflop_preset), .async_reset(async_reset),
    .aflop_q(aflop_q));

  ddrc_pad_model u_pad (.sys_clk(sys_clk), .rst_b(rst_b), .drive_req(drive_req),
    .drive_bit(drive_bit), .dev_o(dev_o));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic ef(input int pos, input logic v);
    return v ^ invert_mask[pos];
  endfunction : ef

  // reset beats set, set beats load
  function automatic logic upd(input logic cur, input logic rv, input logic sv,
                               input logic ce, input logic d);
    if (rv) begin
      return 1'b0;
    end
    if (sv) begin
      return 1'b1;
    end
    return ce ? d : cur;
  endfunction : upd

  initial begin
    sys_clk = 1'b0;
    forever #(ddrc_pkg::SYS_CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      {m_ph, m_cra, m_crb, m_dra, m_drb, m_tra, m_trb, m_po, m_poe, m_sq, m_aq} <= '0;
    end else begin
      rs = ef(ddrc_pkg::INV_RESET, cell_reset);
      st = ef(ddrc_pkg::INV_SET, cell_set);
      if (!m_ph) begin
        nd = upd(m_dra, rs, st, ef(ddrc_pkg::INV_OUT_CE, out_ce),
                 ef(ddrc_pkg::INV_DATA_A, first_data_in));
        nt = upd(m_tra, rs, st, ef(ddrc_pkg::INV_TRI_CE, tri_ce),
                 ef(ddrc_pkg::INV_TRI_A, tri_in_a));
        m_cra <= upd(m_cra, rs, st, ef(ddrc_pkg::INV_IN_CE, in_ce),
                     ef(ddrc_pkg::INV_PIN_IN, pad_level));
        m_dra <= nd;
        m_tra <= nt;
      end else begin
        nd = upd(m_drb, rs, st, ef(ddrc_pkg::INV_OUT_CE, out_ce),
                 ef(ddrc_pkg::INV_DATA_B, second_data_in));
        nt = upd(m_trb, rs, st, ef(ddrc_pkg::INV_TRI_CE, tri_ce),
                 ef(ddrc_pkg::INV_TRI_B, tri_in_b));
        m_crb <= upd(m_crb, rs, st, ef(ddrc_pkg::INV_IN_CE, in_ce),
                     ef(ddrc_pkg::INV_PIN_IN, pad_level));
        m_drb <= nd;
        m_trb <= nt;
      end
      m_po <= nd;
      m_poe <= ~nt;
      m_sq <= upd(m_sq, sflop_reset, sflop_set, sflop_ce, m_ph ? sflop_d1 : sflop_d0);
      m_aq <= upd(m_aq, async_reset, aflop_preset, aflop_ce, m_ph ? aflop_d1 : aflop_d0);
      m_ph <= ~m_ph;
    end
  end

  task automatic check_bit(input string name, input logic exp, input logic seen);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", name, exp, seen);
    end
  endtask : check_bit

  // drive value only matters while the pad is enabled
  task automatic check_pad(input logic exp_o, input logic exp_oe);
    check_bit("pin_oe", exp_oe, pin_oe);
    if (exp_oe) begin
      check_bit("pin_o", exp_o, pin_o);
    end
  endtask : check_pad

  always @(negedge sys_clk) begin
    if (chk_on) begin
      check_bit("phase_a_clock", m_ph, phase_a_clock);
      check_pad(m_po, m_poe);
      check_bit("rise_capture_out", m_cra, rise_capture_out);
      check_bit("fall_capture_out", m_crb, fall_capture_out);
      check_bit("sflop_q", m_sq, sflop_q);
      check_bit("aflop_q", m_aq, aflop_q);
    end
  end

  // with use_mask set, the nine masked bench-driven inputs are sent pre-inverted so the mask is exercised in earnest
  task automatic step(input bit use_mask);
    logic [ddrc_pkg::INV_W-1:0] m;
    logic sv, rv, cv;
    @(posedge sys_clk);
    seed = lfsr_next(seed);
    r = seed;
    seed = lfsr_next(seed);
    m = use_mask ? seed[ddrc_pkg::INV_W-1:0] : '0;
    sv = dir_on ? dir[4] : &r[2:0];
    rv = dir_on ? dir[3] : &r[5:3];
    cv = dir_on ? dir[2] : r[6] | r[7];
    invert_mask <= m;
    cell_set <= sv ^ m[ddrc_pkg::INV_SET];
    cell_reset <= rv ^ m[ddrc_pkg::INV_RESET];
    in_ce <= (dir_on ? cv : r[6] | r[8]) ^ m[ddrc_pkg::INV_IN_CE];
    out_ce <= cv ^ m[ddrc_pkg::INV_OUT_CE];
    tri_ce <= (dir_on ? cv : r[9] | r[8]) ^ m[ddrc_pkg::INV_TRI_CE];
    tri_in_a <= (dir_on ? dir[1] : r[10]) ^ m[ddrc_pkg::INV_TRI_A];
    tri_in_b <= (dir_on ? dir[0] : r[11]) ^ m[ddrc_pkg::INV_TRI_B];
    first_data_in <= r[12] ^ m[ddrc_pkg::INV_DATA_A];
    second_data_in <= r[13] ^ m[ddrc_pkg::INV_DATA_B];
    {sflop_d0, sflop_d1, aflop_d0, aflop_d1} <= r[17:14];
    sflop_ce <= dir_on ? cv : r[18] | r[19];
    aflop_ce <= dir_on ? cv : r[20] | r[19];
    sflop_set <= dir_on ? sv : &r[22:21];
    sflop_reset <= dir_on ? rv : &r[24:23];
    aflop_preset <= dir_on ? sv : &r[26:25];
    async_reset <= dir_on ? rv : &r[28:27];
    drive_req <= r[29];
    drive_bit <= r[30];
  endtask : step

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (10000) @(posedge sys_clk);
    failures++;
    complete_run();
  end

  initial begin
    rst_b = 1'b0;
    invert_mask = '0;
    {cell_set, cell_reset, in_ce, out_ce, tri_ce, first_data_in, second_data_in} = '0;
    {tri_in_a, tri_in_b, sflop_d0, sflop_d1, sflop_ce, sflop_set, sflop_reset} = '0;
    {aflop_d0, aflop_d1, aflop_ce, aflop_preset, async_reset, drive_req, drive_bit} = '0;
    seed = 32'h0001683b;
    dir = '0;
    @(posedge sys_clk);
    chk_on = 1'b1;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    dir_on = 1'b1;
    for (int k = 0; k < 4; k++) begin
      dir = {3'b001, k[1:0]};
      repeat (6) step(1'b0);
    end
    foreach (ctl[i]) begin
      dir = ctl[i];
      repeat (4) step(1'b0);
    end
    dir_on = 1'b0;
    repeat (2000) step(1'b0);
    repeat (2000) step(1'b1);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (500) step(1'b1);
    @(posedge sys_clk);
    complete_run();
  end
endmodule : ddrc_io_cell_tb

`default_nettype wire
